// ==== hw/sram_ctl_pkg.sv ====
// constants for the asynchronous static memory controller
package sram_ctl_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_PS = 20000;
  localparam int T_WP_NS = 8;
  localparam int T_AW_NS = 8;
  localparam int T_CW_NS = 8;
  localparam int T_BW_NS = 8;
  localparam int T_DW_NS = 6;
  localparam int T_RC_NS = 12;
  localparam int T_AA_NS = 12;
  localparam int T_OHZ_NS = 6;
  localparam int T_OW_NS = 3;
  // least times round up, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int WR_PULSE_CYC = cyc_up(T_WP_NS);
  localparam int RD_ACC_CYC = cyc_up(T_AA_NS);
  localparam int HIZ_CYC = cyc_up(T_OHZ_NS);
  localparam int CNT_W = 4;
  // flops between the data pins and any logic that reads them
  localparam int SYNC_STAGES = 2;
  // ==========================================================
  // state machine, gray coded along idle-setup-pulse-end
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WSET = 3'h1,
    ST_WPUL = 3'h3,
    ST_WEND = 3'h2,
    ST_RACC = 3'h6,
    ST_REND = 3'h7,
    ST_TURN = 3'h5
  } state_e;
endpackage

// ==== hw/sram_sync2.sv ====
// two-flop synchroniser for the data pins coming back from the memory
`timescale 1ns/1ps
module sram_sync2 #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== hw/sram_cnt.sv ====
// loadable down-counter used to time strobe phases
`timescale 1ns/1ps
module sram_cnt #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic zero
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  assign cnt_nxt = load ? value : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
  assign zero = (cnt_r == '0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// ==== hw/sram_ctl.sv ====
// host-side controller driving an asynchronous 16-bit static memory
`timescale 1ns/1ps
module sram_ctl #(
  parameter int AW = sram_ctl_pkg::ADDR_W,
  parameter int DW = sram_ctl_pkg::DATA_W,
  parameter int WR_CYC = sram_ctl_pkg::WR_PULSE_CYC,
  parameter int RD_CYC = sram_ctl_pkg::RD_ACC_CYC,
  parameter int TURN_CYC = sram_ctl_pkg::HIZ_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  // user request side
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [AW-1:0] REQ_ADDR,
  input wire logic [DW-1:0] REQ_WDATA,
  input wire logic [1:0] REQ_LANE_EN,
  output logic REQ_READY,
  output logic RD_VALID,
  output logic [DW-1:0] RD_DATA,
  // memory pins
  output logic [AW-1:0] WORD_ADDRESS_BUS,
  output logic SELECT_N,
  output logic OUT_EN_N,
  output logic WRITE_N,
  output logic LOW_LANE_STROBE_N,
  output logic HIGH_LANE_STROBE_N,
  input wire logic [DW-1:0] BIDIR_DATA_BUS_IN,
  output logic [DW-1:0] BIDIR_DATA_BUS_OUT,
  output logic BIDIR_DATA_BUS_OE_N
);
  localparam int CW = sram_ctl_pkg::CNT_W;
  localparam int LW = sram_ctl_pkg::LANE_W;

  // ==========================================================
  // state and registered pin values
  sram_ctl_pkg::state_e st_r, st_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] wdata_r, wdata_nxt;
  logic [1:0] lane_r, lane_nxt;
  logic sel_n_r, sel_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic we_n_r, we_n_nxt;
  logic lb_n_r, lb_n_nxt;
  logic ub_n_r, ub_n_nxt;
  logic dout_en_n_r, dout_en_n_nxt;
  logic ready_r, ready_nxt;
  logic rdv_r, rdv_nxt;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic cnt_load;
  logic [CW-1:0] cnt_val;
  logic cnt_zero;
  logic [DW-1:0] din_s;
  logic [DW-1:0] rd_merge;

  // ==========================================================
  // helpers
  sram_cnt #(.W(CW)) u_cnt (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .load(cnt_load),
    .value(cnt_val),
    .zero(cnt_zero)
  );

  // pins from the memory pass two flops before any use
  // cost: the synchroniser adds two cycles to every read
  sram_sync2 #(.W(DW)) u_sync (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .d(BIDIR_DATA_BUS_IN),
    .q(din_s)
  );

  // keep only enabled lanes; disabled lanes read as zero
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      assign rd_merge[g*LW +: LW] =
        lane_r[g] ? din_s[g*LW +: LW] : '0;
    end
  endgenerate

  // ==========================================================
  // decode; the sequencer reads these named wires
  wire lane_any = (REQ_LANE_EN != 2'h0);
  wire in_idle = (st_r == sram_ctl_pkg::ST_IDLE);
  wire in_wpul = (st_r == sram_ctl_pkg::ST_WPUL);
  wire in_racc = (st_r == sram_ctl_pkg::ST_RACC);
  wire in_turn = (st_r == sram_ctl_pkg::ST_TURN);
  // lane enable 00 is dropped silently and gets no answer; the
  // state term keeps a stray ready from starting a cycle
  wire accept = ready_r && in_idle && REQ_VALID && lane_any;
  wire take_wr = accept && REQ_WRITE;
  // each timed phase ends once the shared counter has run out
  wire wr_close = in_wpul && cnt_zero;
  wire rd_done = in_racc && cnt_zero;
  wire turn_done = in_turn && cnt_zero;
  // lane strobes are active-low copies of the lane enables
  wire [1:0] lane_req_n = ~REQ_LANE_EN;
  wire [1:0] lane_held_n = ~lane_r;

  // sync delay plus access time before sampling the read
  localparam int SYNC_CYC = sram_ctl_pkg::SYNC_STAGES;
  localparam logic [CW-1:0] RD_WAIT = CW'(RD_CYC + SYNC_CYC);
  // one short: the edge that loads the counter is itself a cycle
  localparam logic [CW-1:0] WR_WAIT = CW'(WR_CYC - 1);
  localparam logic [CW-1:0] TURN_WAIT = CW'(TURN_CYC);

  // ==========================================================
  // sequencer
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    lane_nxt = lane_r;
    sel_n_nxt = sel_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    lb_n_nxt = lb_n_r;
    ub_n_nxt = ub_n_r;
    dout_en_n_nxt = dout_en_n_r;
    ready_nxt = ready_r;
    rdv_nxt = 1'b0;
    rdata_nxt = rdata_r;
    cnt_load = 1'b0;
    cnt_val = '0;
    case (st_r)
      sram_ctl_pkg::ST_IDLE: begin
        if (accept) begin
          // address moves only while write is high; a read drops its strobes on this same edge
          addr_nxt = REQ_ADDR;
          lane_nxt = REQ_LANE_EN;
          ready_nxt = 1'b0;
          if (take_wr) begin
            wdata_nxt = REQ_WDATA;
            // bus driven before the window opens, memory off
            dout_en_n_nxt = 1'b0;
            st_nxt = sram_ctl_pkg::ST_WSET;
          end else begin
            sel_n_nxt = 1'b0;
            oe_n_nxt = 1'b0;
            lb_n_nxt = lane_req_n[0];
            ub_n_nxt = lane_req_n[1];
            cnt_load = 1'b1;
            cnt_val = RD_WAIT;
            st_nxt = sram_ctl_pkg::ST_RACC;
          end
        end
      end
      sram_ctl_pkg::ST_WSET: begin
        // write falls together with select and lanes, so the
        // memory never turns its drivers on
        sel_n_nxt = 1'b0;
        we_n_nxt = 1'b0;
        lb_n_nxt = lane_held_n[0];
        ub_n_nxt = lane_held_n[1];
        cnt_load = 1'b1;
        cnt_val = WR_WAIT;
        st_nxt = sram_ctl_pkg::ST_WPUL;
      end
      sram_ctl_pkg::ST_WPUL: begin
        if (wr_close) begin
          // all strobes rise on one edge, closing the window
          sel_n_nxt = 1'b1;
          we_n_nxt = 1'b1;
          lb_n_nxt = 1'b1;
          ub_n_nxt = 1'b1;
          st_nxt = sram_ctl_pkg::ST_WEND;
        end
      end
      sram_ctl_pkg::ST_WEND: begin
        // data and address held one cycle past the close
        dout_en_n_nxt = 1'b1;
        ready_nxt = 1'b1;
        st_nxt = sram_ctl_pkg::ST_IDLE;
      end
      sram_ctl_pkg::ST_RACC: begin
        if (rd_done) begin
          // read data then holds until the next read completes
          rdata_nxt = rd_merge;
          rdv_nxt = 1'b1;
          sel_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          lb_n_nxt = 1'b1;
          ub_n_nxt = 1'b1;
          st_nxt = sram_ctl_pkg::ST_REND;
        end
      end
      sram_ctl_pkg::ST_REND: begin
        // the memory may drive for a while after release
        cnt_load = 1'b1;
        cnt_val = TURN_WAIT;
        st_nxt = sram_ctl_pkg::ST_TURN;
      end
      sram_ctl_pkg::ST_TURN: begin
        // no new request, so no bus drive, until the memory is off
        if (turn_done) begin
          ready_nxt = 1'b1;
          st_nxt = sram_ctl_pkg::ST_IDLE;
        end
      end
      default: begin
        // an illegal state releases every pin on its way to idle
        st_nxt = sram_ctl_pkg::ST_IDLE;
        sel_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        we_n_nxt = 1'b1;
        lb_n_nxt = 1'b1;
        ub_n_nxt = 1'b1;
        dout_en_n_nxt = 1'b1;
        ready_nxt = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // registers; every pin comes from a flop, so no glitches
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r <= sram_ctl_pkg::ST_IDLE;
      ready_r <= 1'b1;
      rdv_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ready_r <= ready_nxt;
      rdv_r <= rdv_nxt;
    end
  end

  // strobes reset high so the memory starts deselected
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sel_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      lb_n_r <= 1'b1;
      ub_n_r <= 1'b1;
      dout_en_n_r <= 1'b1;
    end else begin
      sel_n_r <= sel_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      lb_n_r <= lb_n_nxt;
      ub_n_r <= ub_n_nxt;
      dout_en_n_r <= dout_en_n_nxt;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_r <= '0;
      wdata_r <= '0;
      lane_r <= '0;
      rdata_r <= '0;
    end else begin
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      lane_r <= lane_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign REQ_READY = ready_r;
  assign RD_VALID = rdv_r;
  assign RD_DATA = rdata_r;
  assign WORD_ADDRESS_BUS = addr_r;
  assign SELECT_N = sel_n_r;
  assign OUT_EN_N = oe_n_r;
  assign WRITE_N = we_n_r;
  assign LOW_LANE_STROBE_N = lb_n_r;
  assign HIGH_LANE_STROBE_N = ub_n_r;
  // bus drive enable is active low and stays high outside writes
  assign BIDIR_DATA_BUS_OUT = wdata_r;
  assign BIDIR_DATA_BUS_OE_N = dout_en_n_r;
endmodule

// ==== testbench/sram_model.sv ====
// behavioural model of the asynchronous 16-bit static memory
`timescale 1ns/1ps
module sram_model (
  input wire logic [17:0] addr,
  input wire logic sel_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic lo_n,
  input wire logic hi_n,
  input wire logic [15:0] din,
  output logic [15:0] dout,
  output logic [1:0] drv
);
  logic [15:0] mem [0:262143];
  logic [15:0] word;
  logic open_r = 1'b0;
  logic lo_r = 1'b1;
  logic hi_r = 1'b1;
  // lanes turn on 3 ns late and off within 6 ns
  assign #3 drv[0] = !sel_n && !oe_n && we_n && !lo_n;
  assign #3 drv[1] = !sel_n && !oe_n && we_n && !hi_n;
  // old word stays on the pins a while after the address moves
  assign #3 word = mem[addr];
  // released lanes show the inverse, so a missed lane mask shows up
  assign dout = {drv[1] ? word[15:8] : ~word[15:8],
                 drv[0] ? word[7:0] : ~word[7:0]};
  always @(sel_n, we_n, lo_n, hi_n) begin
    if (open_r && (sel_n || we_n || (lo_n && hi_n))) begin
      if (!lo_r) mem[addr][7:0] = din[7:0];
      if (!hi_r) mem[addr][15:8] = din[15:8];
    end
    open_r = !sel_n && !we_n && !(lo_n && hi_n);
    lo_r = lo_n;
    hi_r = hi_n;
  end
endmodule

// ==== testbench/sram_ctl_sva.sv ====
// pin timing checker for the static memory controller
`timescale 1ns/1ps
module sram_ctl_sva #(
  parameter int AW = 18,
  parameter int DW = 16
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [1:0] REQ_LANE_EN,
  input wire logic REQ_READY,
  input wire logic RD_VALID,
  input wire logic [AW-1:0] WORD_ADDRESS_BUS,
  input wire logic SELECT_N,
  input wire logic OUT_EN_N,
  input wire logic WRITE_N,
  input wire logic LOW_LANE_STROBE_N,
  input wire logic HIGH_LANE_STROBE_N,
  input wire logic [DW-1:0] BIDIR_DATA_BUS_OUT,
  input wire logic BIDIR_DATA_BUS_OE_N
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  wire take = REQ_READY && REQ_VALID && (REQ_LANE_EN != 2'h0);
  wire lo = LOW_LANE_STROBE_N;
  wire hi = HIGH_LANE_STROBE_N;
  // ==========================================================
  // write side
  AST_WR_OVERLAP: assert property (
    $fell(WRITE_N) |-> !SELECT_N && !(lo && hi) ##1 $rose(WRITE_N))
    else $error("write overlap wrong");
  AST_WR_SETUP: assert property (
    $fell(WRITE_N) |-> $past(!BIDIR_DATA_BUS_OE_N) && !BIDIR_DATA_BUS_OE_N
    && $stable(BIDIR_DATA_BUS_OUT)) else $error("write data late");
  AST_WR_HOLD: assert property (
    $rose(WRITE_N) |-> !BIDIR_DATA_BUS_OE_N && $stable(BIDIR_DATA_BUS_OUT))
    else $error("write data not held");
  AST_ADDR_MOVE: assert property (
    !$stable(WORD_ADDRESS_BUS) |-> ($past(WRITE_N) || $past(SELECT_N))
    && (WRITE_N || SELECT_N)) else $error("address moved in write");
  AST_NO_FIGHT: assert property (
    !BIDIR_DATA_BUS_OE_N |-> OUT_EN_N && $past(OUT_EN_N))
    else $error("bus driven against memory");
  AST_WR_LANES: assert property (
    take && REQ_WRITE |-> ##2 !WRITE_N
    && lo == !$past(REQ_LANE_EN[0], 2) && hi == !$past(REQ_LANE_EN[1], 2))
    else $error("write lane strobes wrong");
  // ==========================================================
  // read side
  AST_RD_WINDOW: assert property (
    $fell(OUT_EN_N) |-> (!SELECT_N && WRITE_N)[*4]
    ##1 (OUT_EN_N && SELECT_N && RD_VALID)) else $error("read window wrong");
  AST_RD_LANES: assert property (
    take && !REQ_WRITE |=> !OUT_EN_N && lo == !$past(REQ_LANE_EN[0])
    && hi == !$past(REQ_LANE_EN[1])) else $error("read lane strobes wrong");
  AST_ZERO_LANE: assert property (
    REQ_READY && REQ_VALID && REQ_LANE_EN == 2'h0 |=> REQ_READY && SELECT_N)
    else $error("empty lane request taken");
  COV_WR: cover property (take && REQ_WRITE);
  COV_RD: cover property (take && !REQ_WRITE && REQ_LANE_EN == 2'h2);
  COV_ZERO: cover property (REQ_READY && REQ_VALID && REQ_LANE_EN == 2'h0);
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the static memory controller
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  logic wr = 1'b0;
  logic [17:0] adr = 18'h0;
  logic [15:0] wd = 16'h0;
  logic [1:0] ln = 2'h0;
  logic rdy, rv, sel_n, oe_n, we_n, lo_n, hi_n, boe_n;
  logic [15:0] rdd, bout, bin, mout;
  logic [17:0] madr;
  logic [1:0] mdrv;
  int miscompares = 0;
  int compares = 0;
  always #10 clk = ~clk;
  // wire level: controller while enabled, memory otherwise
  assign bin = !boe_n ? bout : mout;
  sram_ctl i_sram_ctl (
    .REF_CLK(clk), .RST_N(rst_n), .REQ_VALID(vld), .REQ_WRITE(wr),
    .REQ_ADDR(adr), .REQ_WDATA(wd), .REQ_LANE_EN(ln), .REQ_READY(rdy),
    .RD_VALID(rv), .RD_DATA(rdd), .WORD_ADDRESS_BUS(madr),
    .SELECT_N(sel_n), .OUT_EN_N(oe_n), .WRITE_N(we_n),
    .LOW_LANE_STROBE_N(lo_n), .HIGH_LANE_STROBE_N(hi_n),
    .BIDIR_DATA_BUS_IN(bin), .BIDIR_DATA_BUS_OUT(bout),
    .BIDIR_DATA_BUS_OE_N(boe_n));
  sram_model i_sram_model (.addr(madr), .sel_n(sel_n), .oe_n(oe_n),
    .we_n(we_n), .lo_n(lo_n), .hi_n(hi_n), .din(bin), .dout(mout),
    .drv(mdrv));
  // ==========================================================
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge clk);
    #1;
    n++;
    if (n > 40) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic req(input logic w, input logic [17:0] a,
                     input logic [15:0] d, input logic [1:0] l,
                     output logic [15:0] q);
    int n;
    n = 0;
    vld = 1'b1;
    wr = w;
    adr = a;
    wd = d;
    ln = l;
    while (rdy !== 1'b1) tick(n);
    tick(n);
    vld = 1'b0;
    while ((w ? rdy : rv) !== 1'b1) tick(n);
    q = rdd;
  endtask
  task automatic rd_chk(input logic [17:0] a, input logic [1:0] l,
                        input logic [15:0] exp);
    logic [15:0] q;
    req(1'b0, a, 16'h0, l, q);
    check(q, exp);
  endtask
  task automatic wr_do(input logic [17:0] a, input logic [15:0] d,
                       input logic [1:0] l);
    logic [15:0] q;
    req(1'b1, a, d, l, q);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    check({9'h0, rdy, sel_n, oe_n, we_n, lo_n, hi_n, boe_n}, 16'h7f);
  endtask
  task automatic t_full;
    wr_do(18'h0, 16'h1234, 2'h3);
    wr_do(18'h3ffff, 16'ha5c3, 2'h3);
    rd_chk(18'h0, 2'h3, 16'h1234);
    rd_chk(18'h3ffff, 2'h3, 16'ha5c3);
  endtask
  task automatic t_lanes;
    wr_do(18'h5, 16'hbeef, 2'h3);
    wr_do(18'h5, 16'h00ab, 2'h1);
    rd_chk(18'h5, 2'h3, 16'hbeab);
    wr_do(18'h5, 16'hcd00, 2'h2);
    rd_chk(18'h5, 2'h3, 16'hcdab);
    rd_chk(18'h5, 2'h1, 16'h00ab);
    rd_chk(18'h5, 2'h2, 16'hcd00);
  endtask
  task automatic t_zero;
    int n;
    n = 0;
    // the previous read leaves ready low for its turn wait
    while (rdy !== 1'b1) tick(n);
    vld = 1'b1;
    wr = 1'b1;
    adr = 18'h5;
    wd = 16'h0;
    ln = 2'h0;
    repeat (4) begin
      @(posedge clk);
      #1;
      check({14'h0, rdy, sel_n}, 16'h3);
      check({14'h0, mdrv}, 16'h0);
    end
    vld = 1'b0;
    @(posedge clk);
    #1;
    rd_chk(18'h5, 2'h3, 16'hcdab);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_full();
    t_lanes();
    t_zero();
    give_verdict();
  end
endmodule
bind sram_ctl sram_ctl_sva #(.AW(AW), .DW(DW)) i_sram_ctl_sva (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID),
  .REQ_WRITE(REQ_WRITE), .REQ_LANE_EN(REQ_LANE_EN), .REQ_READY(REQ_READY),
  .RD_VALID(RD_VALID), .WORD_ADDRESS_BUS(WORD_ADDRESS_BUS),
  .SELECT_N(SELECT_N), .OUT_EN_N(OUT_EN_N), .WRITE_N(WRITE_N),
  .LOW_LANE_STROBE_N(LOW_LANE_STROBE_N),
  .HIGH_LANE_STROBE_N(HIGH_LANE_STROBE_N),
  .BIDIR_DATA_BUS_OUT(BIDIR_DATA_BUS_OUT),
  .BIDIR_DATA_BUS_OE_N(BIDIR_DATA_BUS_OE_N));
